// file: design/fspa_pkg.sv
// package of register map, fields, codes and reset values for the flash address/protect block
package fspa_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [15:0] IDX_START_LOW   = 16'hFFA4; // start pointer bits 7..0
	localparam logic [15:0] IDX_START_HIGH  = 16'hFFA5; // start pointer bits 11..8
	localparam logic [15:0] IDX_CMP_LOW     = 16'hFFA6; // end compare, low byte
	localparam logic [15:0] IDX_CMP_HIGH    = 16'hFFA7; // end compare, high byte
	localparam logic [15:0] IDX_WBUF        = 16'hFFA8; // write data buffer
	localparam logic [15:0] IDX_PROTECT     = 16'h0081; // protect byte image, read only
	localparam logic [15:0] IDX_IRQ_STATUS  = 16'hFFB0; // sticky event bits, read only
	localparam logic [15:0] IDX_IRQ_CLEAR   = 16'hFFB1; // write one to clear, write only
	localparam logic [15:0] IDX_IRQ_ENABLE  = 16'hFFB2; // interrupt enable mask
	localparam logic [15:0] IDX_SEQ_STATE   = 16'hFFB3; // busy flag and state, read only
	localparam int          ADDR_W          = 18;       // byte address width
	localparam int          IDX_LSB         = 2;        // word select starts here
	// reset values
	localparam logic [7:0]  REG_RESET       = 8'h00;
	// protect byte fields
	localparam int          PSEL_LSB        = 2;        // selection field bits 6..2
	localparam int          PSEL_W          = 5;
	localparam logic [4:0]  PSEL_NONE       = 5'h1F;    // no block protected
	localparam logic [7:0]  PROT_FIXED_MASK = 8'h83;    // bits 7, 1, 0 always one
	// event bit positions
	localparam int          EV_DONE         = 0;        // command finished
	localparam int          EV_PROT_ERR     = 1;        // write/erase protect error
	localparam int          EV_PROHIBITED   = 2;        // protect code not legal
	localparam int          EV_W            = 3;
	// command codes
	localparam logic [2:0]  CMD_VERIFY1     = 3'h1;
	localparam logic [2:0]  CMD_VERIFY2     = 3'h2;
	localparam logic [2:0]  CMD_ERASE       = 3'h3;
	localparam logic [2:0]  CMD_BLANK       = 3'h4;
	localparam logic [2:0]  CMD_WRITE       = 3'h5;
	// bus responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// sequencer states
	typedef enum logic [1:0] {S_IDLE, S_CHECK, S_RUN, S_FINISH} fspa_state_t;
endpackage : fspa_pkg

// file: design/fspa_protect_decode.sv
// decoder from protect selection code to protected lower-block count
`timescale 1ns/1ns
`default_nettype none
module fspa_protect_decode #(
	parameter int BLOCKS = 16 // 4, 8 or 16 blocks of flash
) (
	input  wire logic                        clk,            // checks only, logic is combinational
	input  wire logic                        rst,            // checks sleep through reset
	input  wire logic [fspa_pkg::PSEL_W-1:0] select,         // selection field
	input  wire logic [3:0]                  block,          // targeted block number
	input  wire logic                        self_prog_mode, // protection only acts here
	output logic      [4:0]                  protect_count,  // lowest blocks shielded
	output logic                             prohibited,     // code not legal for variant
	output logic                             blk_protected   // target is shielded
);
	import fspa_pkg::*;

	initial begin
		if (BLOCKS != 4 && BLOCKS != 8 && BLOCKS != 16)
			$error("BLOCKS must be 4, 8 or 16");
	end

	localparam logic [4:0] BLOCKS_N = 5'(BLOCKS);
	logic [4:0] raw_count; // two blocks per step below all ones

	// code 01ccc shields 2*(16-01ccc low nibble) blocks
	always_comb begin
		// doubling by concatenation: a four-bit shift would wrap code 01000 to zero
		raw_count     = {4'(5'h10 - {1'b0, select[3:0]}), 1'b0};
		protect_count = 5'h00;
		prohibited    = 1'b0;
		if (select == PSEL_NONE) begin                   // [R16]
			protect_count = 5'h00;
		end else if (select[4:3] == 2'b01 && raw_count <= BLOCKS_N) begin // [R13] [R14] [R15]
			protect_count = raw_count;
		end else begin
			// unlisted code: shield everything, safer than guessing
			prohibited    = 1'b1;                            // [R16]
			protect_count = BLOCKS_N;
		end
	end

	// other programming modes never see the shield
	assign blk_protected = self_prog_mode && ({1'b0, block} < protect_count); // [R11] [R19]

	property p_none_free;
		@(posedge clk) disable iff (rst)
		(select == PSEL_NONE) |-> (!blk_protected && !prohibited);
	endproperty
	a_none_free: assert property (p_none_free) else $error("all-ones code shields a block"); // [R16]

	property p_mode_only;
		@(posedge clk) disable iff (rst)
		!self_prog_mode |-> !blk_protected;
	endproperty
	a_mode_only: assert property (p_mode_only) else $error("shield outside mode"); // [R11]

endmodule : fspa_protect_decode
`default_nettype wire

// file: design/fspa_top.sv
// flash self-programming address, range, write data and protection block
// Behaviour
// R1 - 12-bit start pointer over two bytes
// R2 - software zeroes upper nibbles before commands
// R3 - compare pair bounds the sequencer walk
// R4 - software mirrors high pointer into compare
// R5 - software loads last low verify address
// R6 - compare registers byte writable, reset zero
// R7 - software puts block number in compare
// R8 - low compare zero erase, ones blank
// R9 - write buffer whole byte, reset zero
// R10 - protect field bits 6..2, others one
// R11 - protection active only in self-programming
// R12 - protected block erase/write has no effect
// R13 - four-block codes decode as listed
// R14 - eight-block codes decode as listed
// R15 - sixteen-block codes shrink two per step
// R16 - all ones free, others prohibited
// R17 - pointer counts up to compare value
// R18 - protected target sets protect error flag
// R19 - check block before any pulse starts
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module fspa_top #(
	parameter int BLOCKS = 16 // flash blocks: 4, 8 or 16
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	// axi4-lite slave
	input  wire logic [fspa_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [fspa_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// from the command/mode logic and flash array
	input  wire logic                          self_prog_mode,
	input  wire logic                          cmd_start,
	input  wire logic [2:0]                    cmd_code,
	input  wire logic [7:0]                    protect_byte_in,
	// toward the flash array
	output logic                               op_valid,
	input  wire logic                          op_ack,
	output logic [2:0]                         op_kind,
	output logic [11:0]                        op_addr,
	output logic [7:0]                         op_data,
	output logic                               busy,
	output logic                               write_erase_protect_error,
	output logic                               irq
);
	import fspa_pkg::*;
	// all checks below sample on the bus clock and sleep through reset
	default clocking chk_cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [7:0]        start_addr_low_reg;   // pointer bits 7..0
	logic [7:0]        start_addr_high_reg;  // pointer bits 11..8 in low nibble
	logic [7:0]        end_compare_low_reg;  // last low address of walk
	logic [7:0]        end_compare_high_reg; // block of walk
	logic [7:0]        write_data_buffer;    // byte to program
	logic [EV_W-1:0]   irq_status;           // sticky events
	logic [EV_W-1:0]   irq_enable;           // interrupt mask
	logic [EV_W-1:0]   ev_set;               // one-cycle event pulses
	fspa_state_t       st;                   // sequencer state
	logic [2:0]        cmd_held;             // command under way
	logic [7:0]        prot_byte;            // protect byte with fixed bits forced
	logic [4:0]        protect_count;        // shielded lower blocks
	logic              prohibited;           // illegal protect code
	logic              blk_protected;        // target block shielded
	logic [11:0]       ptr;                  // full start pointer
	logic [11:0]       cmp;                  // full compare value
	logic              walk_cmd;             // command walks a range
	logic              op_fire;              // array accepted an operation
	// fixed bits read as one whatever the array holds
	assign prot_byte = protect_byte_in | PROT_FIXED_MASK;        // [R10]
	assign ptr       = {start_addr_high_reg[3:0], start_addr_low_reg}; // [R1]
	// upper nibbles ignored; software keeps them zero and equal
	assign cmp       = {end_compare_high_reg[3:0], end_compare_low_reg}; // [R2] [R4]
	assign walk_cmd  = cmd_held inside {CMD_VERIFY1, CMD_VERIFY2, CMD_BLANK};
	assign op_fire   = op_valid && op_ack;
	fspa_protect_decode #(
		.BLOCKS (BLOCKS)
	) fspa_protect_decode_inst (
		.clk            (clk),
		.rst            (rst),
		.select         (prot_byte[PSEL_LSB +: PSEL_W]),
		.block          (start_addr_high_reg[3:0]),
		.self_prog_mode (self_prog_mode),
		.protect_count  (protect_count),
		.prohibited     (prohibited),
		.blk_protected  (blk_protected)
	);

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken in either order
	logic [ADDR_W-1:0] aw_addr;  // held write address
	logic              aw_have;  // address taken
	logic [7:0]        w_byte;   // held lane 0 data
	logic              w_lane0;  // lane 0 strobe held
	logic              w_have;   // data taken
	logic              wr_do;    // perform the write this cycle
	logic [15:0]       wr_idx;   // word index of write
	logic              wr_hit;   // write index is mapped
	assign s_axi_awready = !aw_have && !s_axi_bvalid;
	assign s_axi_wready  = !w_have && !s_axi_bvalid;
	assign wr_do         = aw_have && w_have && !s_axi_bvalid;
	assign wr_idx        = aw_addr[IDX_LSB +: 16];
	// write index decode
	always_comb begin
		case (wr_idx)
			IDX_START_LOW, IDX_START_HIGH, IDX_CMP_LOW, IDX_CMP_HIGH, IDX_WBUF,
			IDX_PROTECT, IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE,
			IDX_SEQ_STATE: wr_hit = 1'b1;
			default:       wr_hit = 1'b0;
		endcase
	end

	// capture address and data, then answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have      <= 1'b0;
			w_have       <= 1'b0;
			aw_addr      <= '0;
			w_byte       <= REG_RESET;
			w_lane0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have  <= 1'b1;
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	logic wr_byte; // lane 0 write landing this cycle
	assign wr_byte = wr_do && w_lane0;

	////////////////////////////////////////////////////////////////////////////
	// start pointer: software load, or sequencer step toward compare
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_addr_low_reg  <= REG_RESET;
			start_addr_high_reg <= REG_RESET;
		end else if (wr_byte && wr_idx == IDX_START_LOW) begin
			start_addr_low_reg  <= w_byte;                   // [R1]
		end else if (wr_byte && wr_idx == IDX_START_HIGH) begin
			start_addr_high_reg <= w_byte;                   // [R1]
		end else if (st == S_RUN && walk_cmd && op_fire && ptr != cmp) begin
			// counter step; software must reload before the next command
			start_addr_high_reg[3:0] <= 4'((ptr + 12'h001) >> 8);       // [R17]
			start_addr_low_reg       <= 8'(ptr + 12'h001);              // [R3] [R17]
		end
	end
	// compare pair and write buffer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			end_compare_low_reg  <= REG_RESET;               // [R6]
			end_compare_high_reg <= REG_RESET;               // [R6]
			write_data_buffer    <= REG_RESET;               // [R9]
		end else if (wr_byte) begin
			case (wr_idx)
				IDX_CMP_LOW:  end_compare_low_reg  <= w_byte; // [R6]
				IDX_CMP_HIGH: end_compare_high_reg <= w_byte; // [R6]
				IDX_WBUF:     write_data_buffer    <= w_byte; // [R9]
				default:      ;
			endcase
		end
	end
	// interrupt enable mask
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq_enable <= '0;
		else if (wr_byte && wr_idx == IDX_IRQ_ENABLE)
			irq_enable <= w_byte[EV_W-1:0];
	end
	// sticky events: a new event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq_status <= '0;
		else if (wr_byte && wr_idx == IDX_IRQ_CLEAR)
			irq_status <= (irq_status & ~w_byte[EV_W-1:0]) | ev_set;
		else
			irq_status <= irq_status | ev_set;
	end
	assign irq                       = |(irq_status & irq_enable);
	assign write_erase_protect_error = irq_status[EV_PROT_ERR];

	////////////////////////////////////////////////////////////////////////////
	// sequencer: check, then one operation or a walk to the compare value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st       <= S_IDLE;
			cmd_held <= 3'h0;
		end else begin
			case (st)
				S_IDLE: if (cmd_start) begin
					cmd_held <= cmd_code;
					st       <= S_CHECK;
				end
				// checked one cycle ahead of any array request
				S_CHECK: begin
					if (blk_protected || !(cmd_held inside {CMD_VERIFY1, CMD_VERIFY2,
							CMD_ERASE, CMD_BLANK, CMD_WRITE}))
						st <= S_IDLE;                            // [R12] [R19]
					else
						st <= S_RUN;
				end
				S_RUN: if (op_fire && (!walk_cmd || ptr == cmp))
					st <= S_FINISH;                              // [R3] [R17]
				S_FINISH: st <= S_IDLE;
				default:  st <= S_IDLE;
			endcase
		end
	end

	// event pulses
	always_comb begin
		ev_set                = '0;
		ev_set[EV_DONE]       = (st == S_FINISH);
		ev_set[EV_PROT_ERR]   = (st == S_CHECK) && (blk_protected || !(cmd_held inside
			{CMD_VERIFY1, CMD_VERIFY2, CMD_ERASE, CMD_BLANK, CMD_WRITE})); // [R18]
		ev_set[EV_PROHIBITED] = (st == S_CHECK) && prohibited; // [R16]
	end
	assign op_valid = (st == S_RUN);                         // [R12]
	assign op_kind  = cmd_held;
	assign op_addr  = ptr;
	assign op_data  = write_data_buffer;
	assign busy     = (st != S_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel: answer one cycle after the address
	logic [15:0] rd_idx; // word index of read
	logic [7:0]  rd_val; // selected register
	logic        rd_hit; // read index mapped
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx        = s_axi_araddr[IDX_LSB +: 16];
	// read mux; the clear register reads zero
	always_comb begin
		rd_hit = 1'b1;
		case (rd_idx)
			IDX_START_LOW:  rd_val = start_addr_low_reg;
			IDX_START_HIGH: rd_val = start_addr_high_reg;
			IDX_CMP_LOW:    rd_val = end_compare_low_reg;
			IDX_CMP_HIGH:   rd_val = end_compare_high_reg;
			IDX_WBUF:       rd_val = write_data_buffer;
			IDX_PROTECT:    rd_val = prot_byte;
			IDX_IRQ_STATUS: rd_val = 8'(irq_status);
			IDX_IRQ_CLEAR:  rd_val = 8'h00;
			IDX_IRQ_ENABLE: rd_val = 8'(irq_enable);
			IDX_SEQ_STATE:  rd_val = {5'h00, busy, 2'(st)};
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_val};
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_ptr_join;
		(wr_byte && wr_idx == IDX_START_HIGH) |=> (op_addr[11:8] == $past(w_byte[3:0]));
	endproperty
	a_ptr_join: assert property (p_ptr_join) else $error("high pointer nibble lost"); // [R1]
	property p_cmp_reset;
		$past(rst) |-> (end_compare_low_reg == 8'h00 && end_compare_high_reg == 8'h00);
	endproperty
	a_cmp_reset: assert property (p_cmp_reset) else $error("compare not zero after reset"); // [R6]
	property p_wbuf_load;
		(wr_byte && wr_idx == IDX_WBUF) |=> (op_data == $past(w_byte));
	endproperty
	a_wbuf_load: assert property (p_wbuf_load) else $error("write buffer not loaded"); // [R9]
	property p_protect_blocks;
		(st == S_CHECK && blk_protected) |=> (!op_valid)[*2];
	endproperty
	a_protect_blocks: assert property (p_protect_blocks) else $error("protected op ran"); // [R12]
	property p_protect_flag;
		(st == S_CHECK && blk_protected) |=> write_erase_protect_error;
	endproperty
	a_protect_flag: assert property (p_protect_flag) else $error("protect error not set"); // [R18]
	property p_check_first;
		$rose(op_valid) |-> ($past(st) == S_CHECK && !$past(blk_protected));
	endproperty
	a_check_first: assert property (p_check_first) else $error("op without check"); // [R19]
	property p_walk_step;
		(op_fire && walk_cmd && ptr != cmp) |=> (op_addr == $past(ptr) + 12'h001 && op_valid);
	endproperty
	a_walk_step: assert property (p_walk_step) else $error("walk did not step"); // [R3]
	property p_walk_end;
		(op_fire && walk_cmd && ptr == cmp) |=> (st == S_FINISH) ##1 (irq_status[EV_DONE]);
	endproperty
	a_walk_end: assert property (p_walk_end) else $error("walk passed compare"); // [R17]

endmodule : fspa_top
`default_nettype wire

// file: testbench/fspa_top_tb.sv
// self-checking bench for the flash address, range and protect block
`timescale 1ns/1ns
`default_nettype none
module fspa_top_tb;
	import fspa_pkg::*;
	logic              clk = 1'b0;   // 25 MHz bench clock
	logic              rst = 1'b1;   // async reset, held at start
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic              self_prog_mode, cmd_start, op_valid, op_ack, busy, irq;
	logic              write_erase_protect_error;
	logic [2:0]        cmd_code, op_kind;
	logic [7:0]        protect_byte_in, op_data, lo;
	logic [11:0]       op_addr;
	logic [31:0]       d;                  // scratch random word
	integer            seed = 74916;       // fixed seed
	int                error_cnt = 0;      // mismatches
	int                num_checks = 0;     // comparisons made
	int                op_cnt = 0;         // array requests accepted
	bit                op_watch = 1'b1;    // compare ops only when their order is known
	logic [1:0]        bq[$];              // expected write responses
	logic [33:0]       rq[$];              // expected {rresp, rdata}
	logic [22:0]       opq[$];             // expected {kind, addr, data}
	logic [15:0]       regs[5] = '{IDX_START_LOW, IDX_START_HIGH, IDX_CMP_LOW, IDX_CMP_HIGH, IDX_WBUF};
	logic [2:0]        walk[3] = '{CMD_VERIFY1, CMD_VERIFY2, CMD_BLANK};

	fspa_top #(.BLOCKS(16)) fspa_top_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .self_prog_mode, .cmd_start,
		.cmd_code, .protect_byte_in, .op_valid, .op_ack, .op_kind, .op_addr, .op_data, .busy,
		.write_erase_protect_error, .irq);

	////////////////////////////////////////////////////////////////////////////////////////
	// clock and a slow, irregular array acknowledge
	always #20 clk = ~clk;
	always @(posedge clk) begin
		op_ack <= (($random(seed) & 3) == 0);
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// compare tasks, one per kind of result
	task automatic report(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : report
	task automatic cmp_b(input logic [1:0] got, input logic [1:0] exp);
		report(40'(got), 40'(exp));
	endtask : cmp_b
	task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
		report(40'(got), 40'(exp));
	endtask : cmp_rd
	task automatic cmp_op(input logic [22:0] got, input logic [22:0] exp);
		report(40'(got), 40'(exp));
	endtask : cmp_op
	task automatic cmp_val(input logic got, input logic exp);
		report(40'(got), 40'(exp));
	endtask : cmp_val

	// watcher: each response, and each op while op_watch is set, takes the oldest note off its queue
	always @(posedge clk) begin
		if (s_axi_bvalid && s_axi_bready)
			cmp_b(s_axi_bresp, bq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			cmp_rd({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (op_valid && op_ack) begin
			op_cnt++;
			if (op_watch)
				cmp_op({op_kind, op_addr, op_data}, opq.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// bus master: both write channels offered together, each released once taken
	task automatic wr(input logic [15:0] idx, input logic [31:0] v, input logic [3:0] st,
			input logic [1:0] er);
		bit aw_ok;
		bit w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		bq.push_back(er);
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= v;
		s_axi_wstrb <= st;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	// byte write with noise in the unused lanes
	task automatic wr8(input logic [15:0] idx, input logic [7:0] v);
		logic [31:0] r;
		r = $random(seed);
		wr(idx, {r[31:8], v}, 4'h1, RESP_OKAY);
	endtask : wr8
	task automatic rd(input logic [15:0] idx, input logic [7:0] v);
		rq.push_back({RESP_OKAY, 24'h0, v});
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	// one command: mode 0 single op, 1 refused with error, 2 range walk
	task automatic run(input logic [2:0] c, input logic [7:0] hi, input logic [7:0] l,
			input logic [7:0] cl, input logic [7:0] en, input int mode, input logic irqx);
		logic [31:0] wb;
		int n0;
		int exp_n;
		wb = $random(seed);
		wr(IDX_IRQ_CLEAR, 32'h7, 4'h1, RESP_OKAY);
		wr8(IDX_IRQ_ENABLE, en);
		wr8(IDX_START_HIGH, hi);
		wr8(IDX_START_LOW, l);
		wr8(IDX_CMP_HIGH, hi);
		wr8(IDX_CMP_LOW, cl);
		wr8(IDX_WBUF, wb[7:0]);
		op_watch = (mode == 0);
		if (mode == 0)
			opq.push_back({c, hi[3:0], l, wb[7:0]});
		n0 = op_cnt;
		// refused: none; single op: one; walk: every address up to the compare value
		exp_n = (mode == 1) ? 0 : (mode == 2) ? int'(cl) - int'(l) + 1 : 1;
		@(posedge clk);
		cmd_code <= c;
		cmd_start <= 1'b1;
		@(posedge clk);
		cmd_start <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		@(posedge clk);
		cmp_val(op_cnt - n0 == exp_n, 1'b1);
		cmp_val(write_erase_protect_error, mode == 1);
		cmp_val(irq, irqx);
	endtask : run

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////////////
	// hang guard, well beyond the thousand or so cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report;
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{self_prog_mode, cmd_start, cmd_code, protect_byte_in} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], REG_RESET);
		// full write lands, write with lane 0 off leaves it alone
		foreach (regs[i]) begin
			d = $random(seed);
			wr(regs[i], d, 4'hF, RESP_OKAY);
			wr(regs[i], ~d, 4'hE, RESP_OKAY);
			rd(regs[i], d[7:0]);
		end
		wr(16'h1234, 32'h0, 4'hF, RESP_SLVERR);
		rd(IDX_IRQ_CLEAR, 8'h00);
		d = $random(seed);
		protect_byte_in <= d[7:0];
		rd(IDX_PROTECT, d[7:0] | PROT_FIXED_MASK);
		// each legal code: top shielded block refused, next one up accepted
		self_prog_mode <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			protect_byte_in <= {1'b1, 5'(8 + k), 2'b11};
			lo = $random(seed);
			run(k[0] ? CMD_WRITE : CMD_ERASE, 8'(15 - 2 * k), lo, 8'h00, 8'h02, 1, 1'b1);
			if (k > 0)
				run(k[0] ? CMD_WRITE : CMD_ERASE, 8'(16 - 2 * k), lo, 8'h00, 8'h02, 0, 1'b0);
		end
		protect_byte_in <= 8'hFF;
		run(CMD_ERASE, 8'h00, lo, 8'h00, 8'h02, 0, 1'b0);
		protect_byte_in <= 8'h83;
		run(CMD_WRITE, 8'h0F, lo, 8'h00, 8'h04, 1, 1'b1);
		// outside self-programming the shield is off
		self_prog_mode <= 1'b0;
		protect_byte_in <= 8'hA3;
		run(CMD_ERASE, 8'h05, lo, 8'h00, 8'h02, 0, 1'b0);
		self_prog_mode <= 1'b1;
		run(CMD_WRITE, 8'h05, lo, 8'h00, 8'h00, 1, 1'b0);
		// range walks end with the pointer on the compare value
		protect_byte_in <= 8'hFF;
		foreach (walk[i]) begin
			lo = 8'hBC + 8'(i) * 8'h20;
			run(walk[i], 8'h02, lo, lo + 8'h03, 8'h01, 2, 1'b1);
			rd(IDX_START_LOW, lo + 8'h03);
		end
		run(3'h6, 8'h02, 8'h00, 8'h00, 8'h02, 1, 1'b1);
		final_report;
	end
endmodule : fspa_top_tb
`default_nettype wire
